// ===== core/tfd_consts.svh
// Constants for the thermal fan duty controller.
// Assumes a 125 MHz core clock; included by bare name.
`ifndef TFD_CONSTS_SVH
`define TFD_CONSTS_SVH
// ==========================================================
// Timing
`define TFD_CLK_NS 8
`define TFD_SEC_NS 1000000000
`define TFD_SEC_CYC (`TFD_SEC_NS / `TFD_CLK_NS)
`define TFD_PWM_PERIOD_NS 31250000
`define TFD_STEPS 64
`define TFD_SLOT_CYC (`TFD_PWM_PERIOD_NS / `TFD_STEPS / `TFD_CLK_NS)
`define TFD_EVAL_LAST 2'h3
`define TFD_WIN_SECS 2'h2
// ==========================================================
// Duty and thresholds
`define TFD_DUTY_FULL 7'h40
`define TFD_DUTY_ZERO 7'h00
`define TFD_MIN_PULSES 6'h20
`define TFD_UPPER_BASE 8'h14
`define TFD_LOWER_BASE 8'h0F
`define TFD_OT_BASE 8'h3C
`define TFD_THR_STEP 8'h05
`define TFD_STRAP_LOW 2'h0
`define TFD_STRAP_OPEN 2'h1
`define TFD_STRAP_HIGH 2'h2
`define TFD_STRAP_RADIX 4'h3
`define TFD_STRAP_SETTLE 2'h3
`define TFD_DG_HIGH 3'h7
`define TFD_DG_LOW 3'h0
// ==========================================================
// APB map
`define TFD_REG_CTRL 12'h000
`define TFD_REG_STATUS 12'h004
`define TFD_REG_THR 12'h008
`define TFD_CTRL_FORCE 0
`define TFD_ST_OT 8
`define TFD_ST_FAIL 9
`define TFD_ST_STATE 10
`define TFD_ST_TEMP 16
`define TFD_THR_LOWER 8
`define TFD_THR_OT 16
`endif

// ===== core/tfd_pkg.sv
// Types shared by the thermal fan duty controller.
// Assumes the constants header supplies all numeric values.
package tfd_pkg;
    // One three-level strap pair; upper strap most significant
    typedef struct packed {
        logic [1:0] hi;
        logic [1:0] lo;
    } tfd_strap_t;

    // Two channel readings in whole degrees Celsius
    typedef struct packed {
        logic [7:0] ch1;
        logic [7:0] ch0;
    } tfd_temps_t;

    typedef enum logic [1:0] {
        TFD_DELAY,
        TFD_SPIN,
        TFD_RUN
    } tfd_state_t;
endpackage

// ===== core/tfd_ctrl.sv
// Thermal fan duty controller: temperature-stepped 32 Hz fan drive
// with overtemperature and fan-failure alarms, APB status/control.
// Assumes digitised channel readings, strap pins coded low/open/high,
// and external pull-ups on every open-drain output.
//
// Notes on behaviour
// - sample both channels once per second
// - shorted or open channel reads zero
// - use larger of two readings
// - overtemperature compare once per second
// - fan threshold compare every four seconds
// - duty has 64 equal steps
// - above upper threshold step up, saturate
// - below lower threshold step down to minimum
// - between thresholds duty holds
// - upper threshold 20 plus 5 per code
// - lower threshold 15 plus 5 per code
// - overtemperature limit chosen in 5 degree steps
// - zero option starts at zero duty
// - start option: delay, full spin, minimum
// - minimum duty fixed parameter, up to 40%
// - zero option spins up on first exceed
// - start option holds minimum until exceed
// - fail detection only at full duty
// - fan fault output active low open drain
// - overtemperature limit 60 plus 5 per code
// - overtemperature alarm releases below limit
// - under 32 pulses in 2 s fails; the code counts pulses over 3 s windows
// - force input gives full duty
`timescale 1ns/100ps
`include "tfd_consts.svh"

module tfd_ctrl #(
    parameter int unsigned SEC_CYC = `TFD_SEC_CYC,
    parameter int unsigned SLOT_CYC = `TFD_SLOT_CYC,
    parameter bit ZERO_MIN_OPT = 1'b0,
    parameter logic [6:0] MIN_DUTY = 7'h13,
    parameter logic [3:0] START_DELAY_S = 4'h2,
    parameter logic [3:0] SPINUP_S = 4'h2
) (
    input wire logic i_mclk,
    input wire logic i_rstn,
    input wire logic i_psel,
    input wire logic i_penable,
    input wire logic i_pwrite,
    input wire logic [11:0] i_paddr,
    input wire logic [31:0] i_pwdata,
    output logic [31:0] o_prdata,
    output logic o_pready,
    output logic o_pslverr,
    input wire tfd_pkg::tfd_temps_t i_diode_sense_in,
    input wire logic [1:0] i_diode_bad,
    input wire tfd_pkg::tfd_strap_t i_upper_thr_sel,
    input wire tfd_pkg::tfd_strap_t i_lower_thr_sel,
    input wire tfd_pkg::tfd_strap_t i_overtemp_sel,
    input wire logic i_fan_tach,
    input wire logic i_force_full_speed,
    output logic o_fan_drive_o,
    output logic o_fan_drive_oe_n,
    output logic o_fan_fault_n_o,
    output logic o_fan_fault_n_oe_n,
    output logic o_overtemp_alarm_n_o,
    output logic o_overtemp_alarm_n_oe_n
);

    // strap decode, base plus five per code index
    function automatic logic [7:0] thr_decode(input tfd_pkg::tfd_strap_t s,
                                              input logic [7:0] base);
        logic [3:0] idx;
        idx = 4'({2'h0, s.hi} * `TFD_STRAP_RADIX + {2'h0, s.lo});
        thr_decode = 8'(base + `TFD_THR_STEP * {4'h0, idx});
    endfunction

    // ==========================================================
    // Pin synchronisers
    localparam int SW = 32;
    logic [SW-1:0] sync_a;
    logic [SW-1:0] sync_b;
    always_ff @(posedge i_mclk or negedge i_rstn) begin
        if (!i_rstn) begin
            sync_a <= '0;
            sync_b <= '0;
        end else begin
            sync_a <= {i_diode_sense_in, i_diode_bad, i_upper_thr_sel,
                       i_lower_thr_sel, i_overtemp_sel, i_fan_tach,
                       i_force_full_speed};
            sync_b <= sync_a;
        end
    end
    tfd_pkg::tfd_temps_t s_temps;
    logic [1:0] s_bad;
    tfd_pkg::tfd_strap_t s_upper;
    tfd_pkg::tfd_strap_t s_lower;
    tfd_pkg::tfd_strap_t s_ot;
    logic s_tach;
    logic s_force;
    assign {s_temps, s_bad, s_upper, s_lower, s_ot, s_tach, s_force} = sync_b;

    // ==========================================================
    // Straps caught once, after synchronisers have filled
    logic [1:0] strap_wait;
    logic [7:0] upper_fan_threshold;
    logic [7:0] lower_fan_threshold;
    logic [7:0] ot_limit;
    always_ff @(posedge i_mclk or negedge i_rstn) begin
        if (!i_rstn) begin
            strap_wait <= 2'h0;
            upper_fan_threshold <= `TFD_UPPER_BASE;
            lower_fan_threshold <= `TFD_LOWER_BASE;
            ot_limit <= `TFD_OT_BASE;
        end else if (strap_wait != `TFD_STRAP_SETTLE) begin
            strap_wait <= 2'(strap_wait + 2'h1);
            upper_fan_threshold <= thr_decode(s_upper, `TFD_UPPER_BASE);
            lower_fan_threshold <= thr_decode(s_lower, `TFD_LOWER_BASE);
            ot_limit <= thr_decode(s_ot, `TFD_OT_BASE);
        end
    end

    // ==========================================================
    // One-second tick and four-second phase
    logic [31:0] sec_cnt;
    logic sec_tick;
    logic tick_d;
    logic [1:0] sec_idx;
    logic eval4;
    always_ff @(posedge i_mclk or negedge i_rstn) begin
        if (!i_rstn) begin
            sec_cnt <= 32'h0;
            sec_tick <= 1'b0;
            tick_d <= 1'b0;
            sec_idx <= 2'h0;
            eval4 <= 1'b0;
        end else begin
            sec_tick <= (sec_cnt == SEC_CYC - 2);
            sec_cnt <= (sec_cnt == SEC_CYC - 1) ? 32'h0 : sec_cnt + 32'h1;
            tick_d <= sec_tick;
            eval4 <= sec_tick && (sec_idx == `TFD_EVAL_LAST);
            if (sec_tick) begin
                sec_idx <= 2'(sec_idx + 2'h1);
            end
        end
    end

    // ==========================================================
    // Temperature sampling
    logic [7:0] temp0;
    logic [7:0] temp1;
    logic [7:0] temp_sel;
    always_ff @(posedge i_mclk or negedge i_rstn) begin
        if (!i_rstn) begin
            temp0 <= 8'h00;
            temp1 <= 8'h00;
        end else if (sec_tick) begin
            // once-per-second sample, bad diode reads zero
            temp0 <= s_bad[0] ? 8'h00 : s_temps.ch0;
            temp1 <= s_bad[1] ? 8'h00 : s_temps.ch1;
        end
    end
    assign temp_sel = (temp0 > temp1) ? temp0 : temp1;

    // ==========================================================
    // Software control
    logic sw_force;
    logic force_any;
    assign force_any = sw_force | s_force;

    // ==========================================================
    // Duty sequencing
    tfd_pkg::tfd_state_t state;
    logic [6:0] duty;
    logic [3:0] timer;
    logic [6:0] floor_duty;
    logic [6:0] drive_duty;
    assign floor_duty = ZERO_MIN_OPT ? `TFD_DUTY_ZERO : MIN_DUTY;
    assign drive_duty = force_any ? `TFD_DUTY_FULL : duty;

    always_ff @(posedge i_mclk or negedge i_rstn) begin
        if (!i_rstn) begin
            state <= ZERO_MIN_OPT ? tfd_pkg::TFD_RUN : tfd_pkg::TFD_DELAY;
            duty <= `TFD_DUTY_ZERO;
            timer <= 4'h0;
        end else begin
            unique case (state)
                tfd_pkg::TFD_DELAY: begin
                    if (tick_d) begin
                        if (timer == START_DELAY_S) begin
                            state <= tfd_pkg::TFD_SPIN;
                            duty <= `TFD_DUTY_FULL;
                            timer <= 4'h0;
                        end else begin
                            timer <= 4'(timer + 4'h1);
                        end
                    end
                end
                tfd_pkg::TFD_SPIN: begin
                    if (tick_d) begin
                        if (timer == SPINUP_S) begin
                            state <= tfd_pkg::TFD_RUN;
                            duty <= MIN_DUTY;
                            timer <= 4'h0;
                        end else begin
                            timer <= 4'(timer + 4'h1);
                        end
                    end
                end
                tfd_pkg::TFD_RUN: begin
                    if (eval4) begin
                        if (temp_sel > upper_fan_threshold) begin
                            if (ZERO_MIN_OPT && duty == `TFD_DUTY_ZERO) begin
                                state <= tfd_pkg::TFD_SPIN;
                                duty <= `TFD_DUTY_FULL;
                                timer <= 4'h0;
                            end else if (duty != `TFD_DUTY_FULL) begin
                                duty <= 7'(duty + 7'h01);
                            end
                        end else if (temp_sel < lower_fan_threshold) begin
                            if (duty > floor_duty) begin
                                duty <= 7'(duty - 7'h01);
                            end
                        end
                    end
                end
            endcase
        end
    end

    // ==========================================================
    // Fan drive waveform
    logic [31:0] slot_cnt;
    logic [5:0] phase;
    // 64 slots per 31.25 ms period
    always_ff @(posedge i_mclk or negedge i_rstn) begin
        if (!i_rstn) begin
            slot_cnt <= 32'h0;
            phase <= 6'h00;
            o_fan_drive_oe_n <= 1'b0;
        end else begin
            if (slot_cnt == SLOT_CYC - 1) begin
                slot_cnt <= 32'h0;
                phase <= 6'(phase + 6'h01);
            end else begin
                slot_cnt <= slot_cnt + 32'h1;
            end
            // released line is pulled high outside: fan on
            o_fan_drive_oe_n <= ({1'b0, phase} < drive_duty);
        end
    end

    // ==========================================================
    // Fan failure detection
    logic [2:0] dg_sh;
    logic dg_lvl;
    logic dg_prev;
    logic [5:0] pulses;
    logic [1:0] win_sec;
    logic fan_fault;
    logic detect_en;
    assign detect_en = (drive_duty == `TFD_DUTY_FULL);
    always_ff @(posedge i_mclk or negedge i_rstn) begin
        if (!i_rstn) begin
            // Tach idles high on its pull-up; no false edge after reset
            dg_sh <= `TFD_DG_HIGH;
            dg_lvl <= 1'b1;
            dg_prev <= 1'b1;
        end else begin
            // Three agreeing samples reject short glitches
            dg_sh <= {dg_sh[1:0], s_tach};
            if (dg_sh == `TFD_DG_HIGH) begin
                dg_lvl <= 1'b1;
            end else if (dg_sh == `TFD_DG_LOW) begin
                dg_lvl <= 1'b0;
            end
            dg_prev <= dg_lvl;
        end
    end
    always_ff @(posedge i_mclk or negedge i_rstn) begin
        if (!i_rstn) begin
            pulses <= 6'h00;
            win_sec <= 2'h0;
            fan_fault <= 1'b0;
        end else if (!detect_en) begin
            pulses <= 6'h00;
            win_sec <= 2'h0;
        end else if (tick_d && win_sec == `TFD_WIN_SECS) begin
            // judge count over three full seconds
            fan_fault <= (pulses < `TFD_MIN_PULSES);
            pulses <= 6'h00;
            win_sec <= 2'h0;
        end else begin
            if (tick_d) begin
                win_sec <= 2'(win_sec + 2'h1);
            end
            if (dg_lvl && !dg_prev && pulses != `TFD_MIN_PULSES) begin
                pulses <= 6'(pulses + 6'h01);
            end
        end
    end

    // ==========================================================
    // Alarm outputs
    logic ot_alarm;
    always_ff @(posedge i_mclk or negedge i_rstn) begin
        if (!i_rstn) begin
            ot_alarm <= 1'b0;
            o_overtemp_alarm_n_oe_n <= 1'b1;
            o_fan_fault_n_oe_n <= 1'b1;
            o_fan_drive_o <= 1'b0;
            o_fan_fault_n_o <= 1'b0;
            o_overtemp_alarm_n_o <= 1'b0;
        end else begin
            // per-second compare, release only below limit
            if (tick_d) begin
                if (temp_sel > ot_limit) begin
                    ot_alarm <= 1'b1;
                end else if (temp_sel < ot_limit) begin
                    ot_alarm <= 1'b0;
                end
            end
            o_overtemp_alarm_n_oe_n <= ~ot_alarm;
            // pull low on failure, else released
            o_fan_fault_n_oe_n <= ~fan_fault;
            o_fan_drive_o <= 1'b0;
            o_fan_fault_n_o <= 1'b0;
            o_overtemp_alarm_n_o <= 1'b0;
        end
    end

    // ==========================================================
    // APB slave, zero wait: data prepared in the setup cycle
    logic setup;
    logic access;
    assign setup = i_psel && !i_penable;
    assign access = i_psel && i_penable && o_pready;
    always_ff @(posedge i_mclk or negedge i_rstn) begin
        if (!i_rstn) begin
            o_pready <= 1'b0;
            o_pslverr <= 1'b0;
            o_prdata <= 32'h0;
        end else begin
            o_pready <= setup;
            o_pslverr <= setup && (i_paddr != `TFD_REG_CTRL)
                && (i_paddr != `TFD_REG_STATUS) && (i_paddr != `TFD_REG_THR);
            if (setup && !i_pwrite) begin
                o_prdata <= 32'h0;
                unique case (i_paddr)
                    `TFD_REG_CTRL: o_prdata[`TFD_CTRL_FORCE] <= sw_force;
                    `TFD_REG_STATUS: begin
                        o_prdata[6:0] <= drive_duty;
                        o_prdata[`TFD_ST_OT] <= ot_alarm;
                        o_prdata[`TFD_ST_FAIL] <= fan_fault;
                        o_prdata[`TFD_ST_STATE +: 2] <= state;
                        o_prdata[`TFD_ST_TEMP +: 8] <= temp_sel;
                    end
                    `TFD_REG_THR: begin
                        o_prdata[7:0] <= upper_fan_threshold;
                        o_prdata[`TFD_THR_LOWER +: 8] <= lower_fan_threshold;
                        o_prdata[`TFD_THR_OT +: 8] <= ot_limit;
                    end
                    default: o_prdata <= 32'h0;
                endcase
            end
        end
    end
    always_ff @(posedge i_mclk or negedge i_rstn) begin
        if (!i_rstn) begin
            sw_force <= 1'b0;
        end else if (access && i_pwrite && i_paddr == `TFD_REG_CTRL) begin
            sw_force <= i_pwdata[`TFD_CTRL_FORCE];
        end
    end

endmodule

// ===== test/tfd_ctrl_monitor.sv
// Port checker for the fan duty controller.
// Assumes one clock domain; bound to every controller instance below.
`timescale 1ns/100ps
module tfd_ctrl_monitor #(
    parameter int unsigned SEC_CYC = 200
) (
    input wire logic i_mclk,
    input wire logic i_rstn,
    input wire logic i_psel,
    input wire logic i_penable,
    input wire logic i_pwrite,
    input wire logic [11:0] i_paddr,
    input wire logic [31:0] o_prdata,
    input wire logic o_pready,
    input wire logic o_pslverr,
    input wire logic i_force_full_speed,
    input wire logic o_fan_drive_o,
    input wire logic o_fan_drive_oe_n,
    input wire logic o_fan_fault_n_o,
    input wire logic o_fan_fault_n_oe_n,
    input wire logic o_overtemp_alarm_n_o,
    input wire logic o_overtemp_alarm_n_oe_n
);
    logic ot_q;
    logic ff_q;
    logic [31:0] ot_gap;
    logic [31:0] ff_gap;
    logic bad_addr;
    assign bad_addr = !(i_paddr inside {12'h000, 12'h004, 12'h008});
    // ====================
    // Spacing of alarm changes, counted in cycles
    always_ff @(posedge i_mclk or negedge i_rstn) begin
        if (!i_rstn) begin
            ot_q <= 1'b1;
            ff_q <= 1'b1;
            ot_gap <= 32'h0;
            ff_gap <= 32'h0;
        end else begin
            ot_q <= o_overtemp_alarm_n_oe_n;
            ff_q <= o_fan_fault_n_oe_n;
            ot_gap <= (ot_q != o_overtemp_alarm_n_oe_n) ? 32'h1 : ot_gap + 32'h1;
            ff_gap <= (ff_q != o_fan_fault_n_oe_n) ? 32'h1 : ff_gap + 32'h1;
        end
    end
    // ====================
    // Properties
    default clocking mon_cb @(posedge i_mclk);
    endclocking
    default disable iff (!i_rstn);
    sequence s_setup;
        i_psel && !i_penable;
    endsequence
    sequence s_force_held;
        i_force_full_speed [*8];
    endsequence
    AST_READY_NEXT: assert property (s_setup |=> o_pready)
        else $error("no ready in the cycle after setup");
    AST_READY_IN_ACCESS: assert property (o_pready |-> i_psel && i_penable)
        else $error("ready outside an access phase");
    AST_ERR_UNMAPPED: assert property (o_pready && bad_addr |->
        o_pslverr && (i_pwrite || o_prdata == 32'h0))
        else $error("unmapped access not refused");
    AST_NO_ERR_MAPPED: assert property (o_pready && !bad_addr |-> !o_pslverr)
        else $error("mapped access refused");
    AST_FORCE_FULL: assert property (s_force_held |-> o_fan_drive_oe_n)
        else $error("drive not full while forced");
    AST_OT_PER_SEC: assert property ((ot_q != o_overtemp_alarm_n_oe_n) |->
        ot_gap >= SEC_CYC - 1)
        else $error("overtemp alarm changed twice within a second");
    AST_FAULT_PER_SEC: assert property ((ff_q != o_fan_fault_n_oe_n) |->
        ff_gap >= SEC_CYC - 1)
        else $error("fan fault changed twice within a second");
    AST_FAULT_AT_FULL: assert property ($fell(o_fan_fault_n_oe_n) |->
        o_fan_drive_oe_n && $past(o_fan_drive_oe_n, 2))
        else $error("fan fault raised away from full duty");
    AST_OPEN_DRAIN_LOW: assert property (!o_fan_drive_o && !o_fan_fault_n_o &&
        !o_overtemp_alarm_n_o)
        else $error("open drain output driven high");
endmodule
bind tfd_ctrl tfd_ctrl_monitor #(.SEC_CYC(SEC_CYC)) mon_u (
    .i_mclk, .i_rstn, .i_psel, .i_penable, .i_pwrite, .i_paddr, .o_prdata,
    .o_pready, .o_pslverr, .i_force_full_speed, .o_fan_drive_o, .o_fan_drive_oe_n,
    .o_fan_fault_n_o, .o_fan_fault_n_oe_n, .o_overtemp_alarm_n_o,
    .o_overtemp_alarm_n_oe_n
);

// ===== test/tfd_fan_model.sv
// Far side of the drive pin: pull-up, drive transistor and fan tach.
// Assumes the bench says through i_healthy whether the rotor turns.
`timescale 1ns/100ps
module tfd_fan_model (
    input wire logic i_mclk,
    input wire logic i_drive_o,
    input wire logic i_drive_oe_n,
    input wire logic i_healthy,
    output logic o_drive_wire,
    output logic o_tach = 1'b1
);
    logic [2:0] ph = 3'h0;
    // ====================
    // Drive line
    // pull-up on drive
    assign o_drive_wire = i_drive_oe_n ? 1'b1 : i_drive_o;
    // ====================
    // Tach: a pulse every 10 cycles while powered; a stalled rotor freezes it
    always @(posedge i_mclk) begin
        if (i_healthy && o_drive_wire) begin
            ph <= (ph == 3'h4) ? 3'h0 : ph + 3'h1;
            if (ph == 3'h4) begin
                o_tach <= ~o_tach;
            end
        end
    end
endmodule

// ===== test/test_tfd_ctrl.sv
// Self-checking bench for the fan duty controller, observed over APB.
// Assumes a shortened second and slot; the fan model plays the far side.
`timescale 1ns/100ps
`include "tfd_consts.svh"
module test_tfd_ctrl;
    localparam int unsigned SEC = 200;
    localparam logic [6:0] MIN = 7'h13;
    logic i_mclk = 1'b0;
    logic i_rstn = 1'b0;
    logic i_psel = 1'b0;
    logic i_penable = 1'b0;
    logic i_pwrite = 1'b0;
    logic [11:0] i_paddr = 12'h000;
    logic [31:0] i_pwdata = 32'h0;
    logic [31:0] o_prdata;
    logic o_pready;
    logic o_pslverr;
    tfd_pkg::tfd_temps_t i_diode_sense_in = 16'h001E;
    logic [1:0] i_diode_bad = 2'h0;
    tfd_pkg::tfd_strap_t i_upper_thr_sel = 4'h6;
    tfd_pkg::tfd_strap_t i_lower_thr_sel = 4'h6;
    tfd_pkg::tfd_strap_t i_overtemp_sel = 4'h6;
    logic i_fan_tach;
    logic i_force_full_speed = 1'b0;
    logic o_fan_drive_o;
    logic o_fan_drive_oe_n;
    logic o_fan_fault_n_o;
    logic o_fan_fault_n_oe_n;
    logic o_overtemp_alarm_n_o;
    logic o_overtemp_alarm_n_oe_n;
    logic healthy = 1'b1;
    logic drv_w;
    logic ff_w;
    logic ot_w;
    logic [31:0] rd;
    logic err;
    logic hit;
    int n_mismatch = 0;
    int check_count = 0;
    int cyc = 0;
    int t0;
    int t1;
    assign ff_w = o_fan_fault_n_oe_n ? 1'b1 : o_fan_fault_n_o;
    assign ot_w = o_overtemp_alarm_n_oe_n ? 1'b1 : o_overtemp_alarm_n_o;
    always #4 i_mclk = ~i_mclk;
    always @(posedge i_mclk) cyc <= cyc + 1;
    tfd_ctrl #(.SEC_CYC(SEC), .SLOT_CYC(2)) dut_u (
        .i_mclk, .i_rstn, .i_psel, .i_penable, .i_pwrite, .i_paddr, .i_pwdata,
        .o_prdata, .o_pready, .o_pslverr, .i_diode_sense_in, .i_diode_bad,
        .i_upper_thr_sel, .i_lower_thr_sel, .i_overtemp_sel, .i_fan_tach,
        .i_force_full_speed, .o_fan_drive_o, .o_fan_drive_oe_n, .o_fan_fault_n_o,
        .o_fan_fault_n_oe_n, .o_overtemp_alarm_n_o, .o_overtemp_alarm_n_oe_n
    );
    tfd_fan_model fan_u (.i_mclk, .i_drive_o(o_fan_drive_o),
        .i_drive_oe_n(o_fan_drive_oe_n), .i_healthy(healthy),
        .o_drive_wire(drv_w), .o_tach(i_fan_tach));
    // ====================
    // Access and compare tasks
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        check_count++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("Error at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] wd);
        int n;
        n = 0;
        @(posedge i_mclk);
        i_psel <= 1'b1;
        i_pwrite <= wr;
        i_paddr <= a;
        i_pwdata <= wd;
        @(posedge i_mclk);
        i_penable <= 1'b1;
        @(posedge i_mclk);
        while (o_pready !== 1'b1) begin
            n++;
            @(posedge i_mclk);
        end
        // Slave answers wait-free; the watchdog ends a hung wait
        check(n, 32'h0);
        rd = o_prdata;
        err = o_pslverr;
        i_psel <= 1'b0;
        i_penable <= 1'b0;
    endtask
    task automatic stat();
        apb(1'b0, `TFD_REG_STATUS, 32'h0);
    endtask
    task automatic duty_is(input logic [6:0] x);
        stat();
        check(rd & 32'h7F, {25'h0, x});
    endtask
    // Polls status for a field value; hit tells whether it came in time
    task automatic wait_stat(input logic [31:0] m, input logic [31:0] v, input int max);
        hit = 1'b0;
        for (int i = 0; i < max && !hit; i++) begin
            stat();
            hit = (rd & m) === v;
        end
        check({31'h0, hit}, 32'h1);
    endtask
    // Syncs on one evaluation, then checks the spacing to the next
    task automatic two_evals(input int dlt);
        logic [6:0] d;
        stat();
        d = rd[6:0];
        wait_stat(32'h7F, {25'h0, 7'(d + dlt)}, 5 * SEC / 3);
        repeat (4 * SEC - 24) @(posedge i_mclk);
        duty_is(7'(d + dlt));
        repeat (40) @(posedge i_mclk);
        duty_is(7'(d + 2 * dlt));
    endtask
    task automatic set_temp(input logic [7:0] t);
        i_diode_sense_in.ch1 <= t;
        wait_stat(32'hFF0000, {8'h0, t, 16'h0}, SEC / 3 + 4);
    endtask
    task automatic end_of_test();
        $display("Checks %0d, mismatches %0d", check_count, n_mismatch);
        if (n_mismatch == 0 && check_count > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask
    // ====================
    // Tests
    initial begin
        logic [3:0] sv [3];
        tfd_pkg::tfd_strap_t st;
        logic [7:0] idx;
        int hc;
        sv = '{4'h0, 4'hA, 4'h6};
        for (int j = 0; j < 3; j++) begin
            st = sv[j];
            idx = 8'h3 * st.hi + st.lo;
            @(posedge i_mclk);
            i_rstn <= 1'b0;
            i_upper_thr_sel <= st;
            i_lower_thr_sel <= st;
            i_overtemp_sel <= st;
            repeat (8) @(posedge i_mclk);
            i_rstn <= 1'b1;
            t0 = cyc;
            repeat (4) @(posedge i_mclk);
            apb(1'b0, `TFD_REG_THR, 32'h0);
            check(rd, {8'h00, `TFD_OT_BASE + `TFD_THR_STEP * idx,
                `TFD_LOWER_BASE + `TFD_THR_STEP * idx,
                `TFD_UPPER_BASE + `TFD_THR_STEP * idx});
            stat();
            check(rd & 32'hC7F, 32'h0);
            check({31'h0, drv_w}, 32'h0);
        end
        apb(1'b0, 12'h00C, 32'h0);
        check({31'h0, err}, 32'h1);
        check(rd, 32'h0);
        $display("strap and map test done");
        wait_stat(32'h7F, 32'h40, 4 * SEC / 3);
        t1 = cyc;
        check({31'h0, t1 - t0 >= 3 * SEC - 8 && t1 - t0 <= 3 * SEC + 8}, 32'h1);
        check((rd >> 10) & 32'h3, 32'h1);
        check({31'h0, drv_w}, 32'h1);
        wait_stat(32'h7F, {25'h0, MIN}, 4 * SEC / 3);
        check({31'h0, cyc - t1 >= 3 * SEC - 8 && cyc - t1 <= 3 * SEC + 8}, 32'h1);
        check((rd >> 10) & 32'h3, 32'h2);
        check({31'h0, ff_w}, 32'h1);
        repeat (8 * SEC) @(posedge i_mclk);
        duty_is(MIN);
        hc = 0;
        repeat (128) begin
            @(posedge i_mclk);
            hc += drv_w;
        end
        check({31'h0, hc == 2 * MIN}, 32'h1);
        $display("power-up test done");
        i_force_full_speed <= 1'b1;
        wait_stat(32'h7F, 32'h40, 8);
        healthy <= 1'b0;
        wait_stat(32'h200, 32'h200, 8 * SEC / 3);
        check({31'h0, ff_w}, 32'h0);
        healthy <= 1'b1;
        wait_stat(32'h200, 32'h0, 8 * SEC / 3);
        check({31'h0, ff_w}, 32'h1);
        i_force_full_speed <= 1'b0;
        wait_stat(32'h7F, {25'h0, MIN}, 8);
        apb(1'b1, `TFD_REG_CTRL, 32'h1);
        wait_stat(32'h7F, 32'h40, 8);
        apb(1'b0, `TFD_REG_CTRL, 32'h0);
        check(rd, 32'h1);
        apb(1'b1, `TFD_REG_CTRL, 32'h0);
        healthy <= 1'b0;
        repeat (5 * SEC) @(posedge i_mclk);
        stat();
        check(rd & 32'h200, 32'h0);
        healthy <= 1'b1;
        $display("force and fault test done");
        i_diode_sense_in.ch0 <= 8'h63;
        i_diode_bad <= 2'h1;
        set_temp(8'h32);
        two_evals(1);
        set_temp(8'h2A);
        stat();
        repeat (8 * SEC) @(posedge i_mclk);
        duty_is(rd[6:0]);
        set_temp(8'h1E);
        two_evals(-1);
        $display("stepping test done");
        set_temp(8'h32);
        wait_stat(32'h7F, 32'h40, 48 * 4 * SEC / 3);
        repeat (8 * SEC) @(posedge i_mclk);
        duty_is(7'h40);
        check({31'h0, drv_w}, 32'h1);
        $display("saturation test done");
        set_temp(8'h55);
        repeat (3 * SEC) @(posedge i_mclk);
        check({31'h0, ot_w}, 32'h1);
        set_temp(8'h56);
        wait_stat(32'h100, 32'h100, 2 * SEC / 3);
        check({31'h0, ot_w}, 32'h0);
        set_temp(8'h55);
        repeat (3 * SEC) @(posedge i_mclk);
        check({31'h0, ot_w}, 32'h0);
        set_temp(8'h54);
        wait_stat(32'h100, 32'h0, 2 * SEC / 3);
        check({31'h0, ot_w}, 32'h1);
        $display("overtemperature test done");
        end_of_test();
    end
    // Run is about 49k cycles; the limit leaves wide margin
    initial begin
        repeat (90000) @(posedge i_mclk);
        n_mismatch++;
        end_of_test();
    end
endmodule
